// ===== src/scr_control_regs.sv
// serializer control registers behind an i2c-compatible slave, with video capture and clock watch
module scr_control_regs (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire logic [2:0]       address_select_pin,
  input  wire logic             pclk_in,
  input  wire scr_pkg::scr_vid_s vid_in,
  input  wire logic             link_detected,
  input  wire logic [6:0]       remote_target_addr,
  output scr_pkg::scr_fwd_s     fwd,
  input  wire logic             fwd_ack_valid,
  input  wire logic             fwd_ack,
  input  wire logic             fwd_rdata_valid,
  input  wire logic [7:0]       fwd_rdata,
  output scr_pkg::scr_vid_s     vid_out,
  output logic                  vid_strobe,
  output logic                  power_down,
  output logic                  osc_select,
  output logic                  crc_check_en,
  output logic                  pass_through_en,
  output logic                  full_logic_reset,
  output logic                  logic_reset_keep_regs,
  output logic [6:0]            active_slave_addr
);

  typedef struct packed {
    scr_pkg::scr_i2c_e      st;
    logic [3:0]             bitcnt;
    logic [7:0]             shreg;
    logic                   rw;
    logic                   remote;
    logic                   first;
    logic                   mnack;
    logic                   sda_drv;
    logic                   scl_hold;
    logic                   rd_wait;
    logic [7:0]             ptr;
    logic [6:0]             dev_addr;
    logic                   addr_ovr;
    logic                   sleep;
    logic                   rst_full;
    logic                   rst_keep;
    logic [7:0]             cfg;
    logic [2:0]             scl_s;
    logic [2:0]             sda_s;
    logic [2:0]             pclk_s;
    logic [2:0]             id_s0;
    logic [2:0]             id_s1;
    scr_pkg::scr_vid_s      vid_s0;
    scr_pkg::scr_vid_s      vid_s1;
    logic [23:0]            rgb_cap;
    logic                   strobe;
    logic [scr_pkg::LOSS_W-1:0] loss_cnt;
    logic                   pclk_absent;
    scr_pkg::scr_fwd_s      fwd;
  } scr_state_s;

  scr_state_s q;
  scr_state_s d;
  logic [2:0] filt_in;
  logic [2:0] filt_out;
  logic       filt_clear;

  function automatic logic [7:0] reg_read(input scr_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = scr_pkg::UNMAPPED_READ;
    unique case (a)
      scr_pkg::ADDR_REG_OFS: v = {s.dev_addr, s.addr_ovr};
      scr_pkg::RST_REG_OFS:  v = {s.sleep, 5'h00, s.rst_full, s.rst_keep};
      scr_pkg::CFG_REG_OFS:  v = s.cfg;
      default:               v = scr_pkg::UNMAPPED_READ;
    endcase
    return v;
  endfunction

  function automatic scr_state_s reg_write(input scr_state_s s, input logic [7:0] a, input logic [7:0] v);
    scr_state_s r;
    r = s;
    unique case (a)
      scr_pkg::ADDR_REG_OFS: begin
        r.dev_addr = v[7:1];
        r.addr_ovr = v[scr_pkg::ADDR_OVR_BIT];
      end
      scr_pkg::RST_REG_OFS: begin
        r.sleep    = v[scr_pkg::SLEEP_BIT];
        r.rst_full = v[scr_pkg::FULL_RST_BIT];
        r.rst_keep = v[scr_pkg::KEEP_RST_BIT];
      end
      scr_pkg::CFG_REG_OFS: begin
        r.cfg = (v & scr_pkg::CFG_RW_MASK) | (scr_pkg::CFG_REG_RST & ~scr_pkg::CFG_RW_MASK);
      end
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic scr_state_s begin_read(input scr_state_s s);
    scr_state_s r;
    r = s;
    if (s.remote) begin
      r.fwd.rd_req = 1'b1;
      r.rd_wait    = 1'b1;
      r.scl_hold   = 1'b1;
      r.sda_drv    = 1'b0;
      r.st         = scr_pkg::I2C_WAIT;
    end else begin
      r.shreg   = reg_read(s, s.ptr);
      r.ptr     = 8'(s.ptr + 8'h01);
      r.sda_drv = ~r.shreg[7];
      r.bitcnt  = 4'h1;
      r.st      = scr_pkg::I2C_RD;
    end
    return r;
  endfunction

  logic       scl_now;
  logic       sda_now;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       pclk_rise;
  logic       pclk_fall;
  logic       cap_edge;
  logic [6:0] own_addr;

  always_comb begin
    scl_now   = q.scl_s[1];
    sda_now   = q.sda_s[1];
    scl_rise  = scl_now & ~q.scl_s[2];
    scl_fall  = ~scl_now & q.scl_s[2];
    bus_start = scl_now & q.scl_s[2] & q.sda_s[2] & ~sda_now;
    bus_stop  = scl_now & q.scl_s[2] & ~q.sda_s[2] & sda_now;
    pclk_rise = q.pclk_s[1] & ~q.pclk_s[2];
    pclk_fall = ~q.pclk_s[1] & q.pclk_s[2];
    cap_edge  = q.cfg[scr_pkg::CFG_EDGE_BIT] ? pclk_rise : pclk_fall;
    own_addr  = q.addr_ovr ? q.dev_addr : scr_pkg::PIN_ADDR_TABLE[q.id_s1];

    d = q;
    d.scl_s     = {q.scl_s[1], q.scl_s[0], scl_in};
    d.sda_s     = {q.sda_s[1], q.sda_s[0], sda_in};
    d.pclk_s    = {q.pclk_s[1], q.pclk_s[0], pclk_in};
    d.id_s0     = address_select_pin;
    d.id_s1     = q.id_s0;
    d.vid_s0    = vid_in;
    d.vid_s1    = q.vid_s0;
    d.fwd.start = 1'b0;
    d.fwd.stop  = 1'b0;
    d.fwd.valid = 1'b0;
    d.fwd.rd_req = 1'b0;
    d.rst_full  = 1'b0;
    d.rst_keep  = 1'b0;

    if (q.rst_full) begin
      d.dev_addr = scr_pkg::ADDR_REG_RST[7:1];
      d.addr_ovr = scr_pkg::ADDR_REG_RST[scr_pkg::ADDR_OVR_BIT];
      d.sleep    = scr_pkg::RST_REG_RST[scr_pkg::SLEEP_BIT];
      d.cfg      = scr_pkg::CFG_REG_RST;
      d.ptr      = 8'h00;
    end

    if (bus_stop) begin
      d.fwd.stop = q.remote;
      d.st       = scr_pkg::I2C_IDLE;
      d.sda_drv  = 1'b0;
      d.scl_hold = 1'b0;
      d.rd_wait  = 1'b0;
      d.remote   = 1'b0;
    end else if (bus_start) begin
      d.st       = scr_pkg::I2C_ADDR;
      d.bitcnt   = 4'h0;
      d.sda_drv  = 1'b0;
      d.scl_hold = 1'b0;
      d.rd_wait  = 1'b0;
    end else begin
      unique case (q.st)
        scr_pkg::I2C_IDLE: begin
          d.sda_drv = 1'b0;
        end
        scr_pkg::I2C_ADDR: begin
          if (scl_rise) begin
            d.shreg  = {q.shreg[6:0], sda_now};
            d.bitcnt = 4'(q.bitcnt + 4'h1);
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            d.rw     = q.shreg[0];
            d.bitcnt = 4'h0;
            if (q.shreg[7:1] == own_addr) begin
              d.remote  = 1'b0;
              d.first   = 1'b1;
              d.sda_drv = 1'b1;
              d.st      = scr_pkg::I2C_ACK;
            end else if (q.shreg[7:1] == remote_target_addr || q.cfg[scr_pkg::CFG_PASS_BIT]) begin
              d.remote    = 1'b1;
              d.fwd.start = 1'b1;
              d.fwd.valid = 1'b1;
              d.fwd.data  = q.shreg;
              if (q.cfg[scr_pkg::CFG_AUTOACK_BIT] && !q.shreg[0]) begin
                d.sda_drv = 1'b1;
                d.st      = scr_pkg::I2C_ACK;
              end else begin
                d.scl_hold = 1'b1;
                d.st       = scr_pkg::I2C_WAIT;
              end
            end else begin
              d.st = scr_pkg::I2C_IDLE;
            end
          end
        end
        scr_pkg::I2C_WAIT: begin
          if (q.rd_wait && fwd_rdata_valid) begin
            d.shreg    = fwd_rdata;
            d.rd_wait  = 1'b0;
            d.scl_hold = 1'b0;
            d.sda_drv  = ~fwd_rdata[7];
            d.bitcnt   = 4'h1;
            d.st       = scr_pkg::I2C_RD;
          end else if (!q.rd_wait && fwd_ack_valid) begin
            d.scl_hold = 1'b0;
            d.sda_drv  = fwd_ack;
            d.st       = scr_pkg::I2C_ACK;
          end
        end
        scr_pkg::I2C_ACK: begin
          if (scl_fall) begin
            if (!q.sda_drv) begin
              d.st = scr_pkg::I2C_IDLE;
            end else if (q.rw) begin
              d = begin_read(d);
            end else begin
              d.sda_drv = 1'b0;
              d.bitcnt  = 4'h0;
              d.st      = scr_pkg::I2C_WR;
            end
          end
        end
        scr_pkg::I2C_WR: begin
          if (scl_rise) begin
            d.shreg  = {q.shreg[6:0], sda_now};
            d.bitcnt = 4'(q.bitcnt + 4'h1);
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            d.bitcnt = 4'h0;
            if (q.remote) begin
              d.fwd.valid = 1'b1;
              d.fwd.data  = q.shreg;
              if (q.cfg[scr_pkg::CFG_AUTOACK_BIT]) begin
                d.sda_drv = 1'b1;
                d.st      = scr_pkg::I2C_ACK;
              end else begin
                d.scl_hold = 1'b1;
                d.st       = scr_pkg::I2C_WAIT;
              end
            end else begin
              if (q.first) begin
                d.ptr   = q.shreg;
                d.first = 1'b0;
              end else begin
                d     = reg_write(d, q.ptr, q.shreg);
                d.ptr = 8'(q.ptr + 8'h01);
              end
              d.sda_drv = 1'b1;
              d.st      = scr_pkg::I2C_ACK;
            end
          end
        end
        scr_pkg::I2C_RD: begin
          if (scl_fall) begin
            if (q.bitcnt == 4'h8) begin
              d.sda_drv = 1'b0;
              d.st      = scr_pkg::I2C_MACK;
            end else begin
              d.sda_drv = ~q.shreg[3'(4'h7 - q.bitcnt)];
              d.bitcnt  = 4'(q.bitcnt + 4'h1);
            end
          end
        end
        scr_pkg::I2C_MACK: begin
          if (scl_rise) begin
            d.mnack = sda_now;
          end else if (scl_fall) begin
            if (q.mnack) begin
              d.st = scr_pkg::I2C_IDLE;
            end else begin
              d = begin_read(d);
            end
          end
        end
        default: begin
          d.st       = scr_pkg::I2C_IDLE;
          d.sda_drv  = 1'b0;
          d.scl_hold = 1'b0;
        end
      endcase
    end

    d.strobe = cap_edge;
    if (cap_edge) begin
      d.rgb_cap = q.vid_s1.rgb;
    end
    if (pclk_rise || pclk_fall) begin
      d.loss_cnt    = '0;
      d.pclk_absent = 1'b0;
    end else if (q.loss_cnt == scr_pkg::LOSS_LAST) begin
      d.pclk_absent = 1'b1;
    end else begin
      d.loss_cnt = scr_pkg::LOSS_W'(q.loss_cnt + 1'b1);
    end

    if (q.rst_full || q.rst_keep) begin
      d.rgb_cap     = 24'h000000;
      d.strobe      = 1'b0;
      d.loss_cnt    = '0;
      d.pclk_absent = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.st       <= scr_pkg::I2C_IDLE;
      q.dev_addr <= scr_pkg::ADDR_REG_RST[7:1];
      q.addr_ovr <= scr_pkg::ADDR_REG_RST[scr_pkg::ADDR_OVR_BIT];
      q.sleep    <= scr_pkg::RST_REG_RST[scr_pkg::SLEEP_BIT];
      q.cfg      <= scr_pkg::CFG_REG_RST;
      q.scl_s    <= 3'h7;
      q.sda_s    <= 3'h7;
      q.mnack    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign filt_in    = {q.vid_s1.hs, q.vid_s1.vs, q.vid_s1.de};
  assign filt_clear = q.rst_full | q.rst_keep;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      scr_sync_filter u_filt (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .clear  (filt_clear),
        .strobe (cap_edge),
        .enable (q.cfg[scr_pkg::CFG_FILT_BIT]),
        .din    (filt_in[gi]),
        .dout   (filt_out[gi])
      );
    end
  endgenerate

  assign vid_out               = {q.rgb_cap, filt_out};
  assign vid_strobe            = q.strobe;
  assign scl_out               = 1'b0;
  assign sda_out               = 1'b0;
  assign scl_oe                = q.scl_hold;
  assign sda_oe                = q.sda_drv;
  assign fwd                   = q.fwd;
  assign power_down            = q.sleep & ~link_detected;
  assign osc_select            = q.cfg[scr_pkg::CFG_PCLK_AUTO_BIT] & q.pclk_absent;
  assign crc_check_en          = q.cfg[scr_pkg::CFG_CRC_BIT];
  assign pass_through_en       = q.cfg[scr_pkg::CFG_PASS_BIT];
  assign full_logic_reset      = q.rst_full;
  assign logic_reset_keep_regs = q.rst_keep;
  assign active_slave_addr     = own_addr;

endmodule

// ===== src/scr_pkg.sv
// shared constants and types of the serializer control register bank
package scr_pkg;

  localparam logic [7:0] ADDR_REG_OFS      = 8'h00;
  localparam logic [7:0] RST_REG_OFS       = 8'h01;
  localparam logic [7:0] CFG_REG_OFS       = 8'h03;

  localparam int         ADDR_OVR_BIT      = 0;
  localparam int         SLEEP_BIT         = 7;
  localparam int         FULL_RST_BIT      = 1;
  localparam int         KEEP_RST_BIT      = 0;
  localparam int         CFG_CRC_BIT       = 7;
  localparam int         CFG_AUTOACK_BIT   = 5;
  localparam int         CFG_FILT_BIT      = 4;
  localparam int         CFG_PASS_BIT      = 3;
  localparam int         CFG_PCLK_AUTO_BIT = 1;
  localparam int         CFG_EDGE_BIT      = 0;

  localparam logic [7:0] ADDR_REG_RST      = 8'h00;
  localparam logic [7:0] RST_REG_RST       = 8'h00;
  localparam logic [7:0] CFG_REG_RST       = 8'hd2;
  localparam logic [7:0] CFG_RW_MASK       = 8'hbb;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // pin-selected slave addresses, index is the address select code
  localparam logic [7:0][6:0] PIN_ADDR_TABLE = {7'h1a, 7'h18, 7'h16, 7'h14, 7'h12, 7'h10, 7'h0e, 7'h0c};

  localparam int         MCLK_PERIOD_NS    = 25;
  localparam int         PCLK_LOSS_NS      = 1000;
  localparam int         PCLK_LOSS_CYC     = (PCLK_LOSS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int         LOSS_W            = $clog2(PCLK_LOSS_CYC + 1);
  localparam logic [LOSS_W-1:0] LOSS_LAST  = LOSS_W'(PCLK_LOSS_CYC - 1);
  localparam int         FILTER_MIN_STROBES = 2;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK  = 3'b011,
    I2C_WR   = 3'b010,
    I2C_RD   = 3'b110,
    I2C_MACK = 3'b111,
    I2C_WAIT = 3'b101
  } scr_i2c_e;

  typedef struct packed {
    logic [23:0] rgb;
    logic        hs;
    logic        vs;
    logic        de;
  } scr_vid_s;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       valid;
    logic       rd_req;
    logic [7:0] data;
  } scr_fwd_s;

  typedef struct packed {
    logic       dout;
    logic [1:0] cnt;
  } scr_filt_s;

endpackage

// ===== src/scr_sync_filter.sv
// two-strobe pulse filter for one sync or valid input
module scr_sync_filter (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic strobe,
  input  wire logic enable,
  input  wire logic din,
  output logic      dout
);

  scr_pkg::scr_filt_s q;
  scr_pkg::scr_filt_s d;

  always_comb begin
    d = q;
    if (clear) begin
      d = '0;
    end else if (strobe) begin
      if (!enable) begin
        d.dout = din;
        d.cnt  = 2'h0;
      end else if (din == q.dout) begin
        d.cnt = 2'h0;
      end else if (q.cnt == 2'(scr_pkg::FILTER_MIN_STROBES - 1)) begin
        d.dout = din;
        d.cnt  = 2'h0;
      end else begin
        d.cnt = 2'(q.cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.dout;

endmodule

// ===== verif/scr_control_checker.sv
// port assertions for the serializer control register bank
module scr_control_checker (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              scl_oe,
  input wire logic [2:0]        address_select_pin,
  input wire logic              pclk_in,
  input wire logic              link_detected,
  input wire scr_pkg::scr_fwd_s fwd,
  input wire logic              fwd_ack_valid,
  input wire logic              vid_strobe,
  input wire logic              power_down,
  input wire logic              osc_select,
  input wire logic              crc_check_en,
  input wire logic              pass_through_en,
  input wire logic              full_logic_reset,
  input wire logic              logic_reset_keep_regs,
  input wire logic [6:0]        active_slave_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [5:0] quiet_reg;
  logic [2:0] pclk_s_reg;
  // cycles since the synchronised pixel clock last moved, aligned with the block's own edge detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg  <= 6'h00;
      pclk_s_reg <= 3'h0;
    end else begin
      pclk_s_reg <= {pclk_s_reg[1:0], pclk_in};
      if (pclk_s_reg[1] != pclk_s_reg[2]) begin
        quiet_reg <= 6'h00;
      end else if (quiet_reg != 6'h3f) begin
        quiet_reg <= quiet_reg + 6'h01;
      end
    end
  end
  AST_PWR_LINK: assert property (power_down |-> !link_detected)
    else $error("power down while link present");
  AST_OSC_QUIET: assert property (osc_select |-> quiet_reg >= 6'h1e)
    else $error("oscillator switch with pixel clock running");
  AST_FULL_PULSE: assert property (full_logic_reset |=> !full_logic_reset)
    else $error("full reset not self clearing");
  AST_FULL_DEFAULTS: assert property (full_logic_reset |-> ##2 (crc_check_en && !pass_through_en))
    else $error("full reset left configuration");
  AST_KEEP_PULSE: assert property ($rose(logic_reset_keep_regs) |=> $fell(logic_reset_keep_regs))
    else $error("logic reset not self clearing");
  AST_STROBE_EDGE: assert property (vid_strobe |-> quiet_reg == 6'h00)
    else $error("capture strobe without pixel edge");
  AST_PIN_ADDR: assert property (full_logic_reset |-> ##4
    (active_slave_addr == scr_pkg::PIN_ADDR_TABLE[address_select_pin]))
    else $error("pin address not used after reset");
  AST_STRETCH_RELEASE: assert property (fwd_ack_valid && scl_oe |=> !scl_oe)
    else $error("clock stretch held after remote answer");
  AST_FWD_START: assert property (fwd.start |-> fwd.valid ##1 !fwd.start)
    else $error("forwarded start malformed");
endmodule
bind scr_control_regs scr_control_checker u_chk (
  .mclk(mclk), .rst_n(rst_n), .scl_oe(scl_oe), .address_select_pin(address_select_pin),
  .pclk_in(pclk_in), .link_detected(link_detected), .fwd(fwd), .fwd_ack_valid(fwd_ack_valid),
  .vid_strobe(vid_strobe), .power_down(power_down), .osc_select(osc_select),
  .crc_check_en(crc_check_en), .pass_through_en(pass_through_en), .full_logic_reset(full_logic_reset),
  .logic_reset_keep_regs(logic_reset_keep_regs), .active_slave_addr(active_slave_addr));

// ===== verif/scr_host_model.sv
// serial bus host model driving open-drain clock and data
module scr_host_model (
  input  wire logic mclk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 8;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    hw(H);
    sda_oe = 1'b1;
    hw(H);
    scl_oe = 1'b1;
    hw(H);
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    hw(H);
    scl_oe = 1'b0;
    hw(H);
    sda_oe = 1'b0;
    hw(H);
  endtask
  // one bit; waits out clock stretching by the slave
  task automatic bitx(input logic b, output logic r);
    int i;
    sda_oe = ~b;
    hw(H);
    scl_oe = 1'b0;
    for (i = 0; i < 2000 && !scl; i++) hw(1);
    hw(H);
    r = sda;
    scl_oe = 1'b1;
    hw(H);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // reads one byte and ends the read with a nack
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
  endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the serializer control register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk = 1'b0, rst_n = 1'b0, link = 1'b1, pclk = 1'b0, prun = 1'b1;
  logic              fav = 1'b0, frv = 1'b0, rack = 1'b1, ack, hscl, hsda, scl_oe, sda_oe;
  logic              pd, osc, crc, pte, frst, krst, vstb;
  logic [2:0]        pin;
  logic [6:0]        act, pa, a;
  logic [7:0]        rd, d;
  logic [3:0]        da = 4'h0, dr = 4'h0;
  logic [31:0]       seed = 32'h420424b5, r;
  int                err_total = 0, comparisons = 0, nfull = 0, nkeep = 0, nstart = 0;
  logic              fix = 1'b0;
  logic [2:0]        sy = 3'h0;
  logic [6:0]        rta = 7'h40;
  logic [7:0]        frd = 8'h5a;
  scr_pkg::scr_vid_s vid = '0, vr = '0, vf = '0, vo;
  scr_pkg::scr_fwd_s fwd;
  wire scl = ~(scl_oe | hscl);
  wire sda = ~(sda_oe | hsda);
  scr_control_regs dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .address_select_pin(pin), .pclk_in(pclk),
    .vid_in(vid), .link_detected(link), .remote_target_addr(rta), .fwd(fwd),
    .fwd_ack_valid(fav), .fwd_ack(rack), .fwd_rdata_valid(frv), .fwd_rdata(frd),
    .vid_out(vo), .vid_strobe(vstb), .power_down(pd), .osc_select(osc), .crc_check_en(crc),
    .pass_through_en(pte), .full_logic_reset(frst), .logic_reset_keep_regs(krst),
    .active_slave_addr(act));
  scr_host_model h (.mclk(mclk), .scl(scl), .sda(sda), .scl_oe(hscl), .sda_oe(hsda));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always #12.5 mclk = ~mclk;
  // pixel clock and random video
  always begin
    repeat (12) @(posedge mclk);
    #1;
    if (prun) pclk = ~pclk;
    r = xs();
    vid = {r[26:3], fix ? sy : r[2:0]};
    if (pclk) begin
      vr = vid;
    end else begin
      vf = vid;
    end
  end
  // remote side answers a few cycles after each request
  always @(posedge mclk) begin
    #1;
    da <= {da[2:0], fwd.valid};
    dr <= {dr[2:0], fwd.rd_req};
    fav <= da[3];
    frv <= dr[3];
    nfull <= nfull + int'(frst);
    nkeep <= nkeep + int'(krst);
    nstart <= nstart + int'(fwd.start);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: %s saw %h want %h", $time, m, s, e);
    end
  endtask
  task automatic probe(input logic [6:0] x);
    h.start();
    h.wbyte({x, 1'b0}, ack);
    h.stop();
  endtask
  task automatic wr(input logic [6:0] x, input logic [7:0] o, input logic [7:0] v);
    h.start();
    h.wbyte({x, 1'b0}, ack);
    h.wbyte(o, ack);
    h.wbyte(v, ack);
    h.stop();
  endtask
  task automatic rdr(input logic [6:0] x, input logic [7:0] o);
    h.start();
    h.wbyte({x, 1'b0}, ack);
    h.wbyte(o, ack);
    h.stop();
    h.start();
    h.wbyte({x, 1'b1}, ack);
    h.rbyte(rd);
    h.stop();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    pin = 3'(xs());
    pa = 7'h0c + {3'h0, pin, 1'b0};
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    h.hw(4);
    rdr(pa, 8'h00);
    chk(rd, 8'h00, "address reg default");
    rdr(pa, 8'h01);
    chk(rd, 8'h00, "reset reg default");
    rdr(pa, 8'h03);
    chk(rd, 8'hd2, "config default");
    rdr(pa, 8'h02);
    chk(rd, 8'h00, "unmapped read");
    chk({1'b0, act}, {1'b0, pa}, "pin address");
    $display("test defaults done");
    a = {3'h6, 4'(xs())};
    wr(pa, 8'h00, {a, 1'b1});
    rdr(a, 8'h00);
    chk(rd, {a, 1'b1}, "address readback");
    chk({1'b0, act}, {1'b0, a}, "override address");
    probe(pa);
    chk({7'h0, ack}, 8'h00, "pin address ignored");
    wr(a, 8'h00, {a, 1'b0});
    chk({1'b0, act}, {1'b0, pa}, "back to pin");
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(xs());
      wr(pa, 8'h03, d);
      rdr(pa, 8'h03);
      chk(rd, (d & 8'hbb) | 8'h40, "config readback");
      chk({7'h0, crc}, {7'h0, d[7]}, "crc enable");
      chk({7'h0, pte}, {7'h0, d[3]}, "pass enable");
    end
    $display("test config done");
    wr(pa, 8'h01, 8'hfc);
    rdr(pa, 8'h01);
    chk(rd, 8'h80, "sleep readback");
    link = 1'b0;
    h.hw(2);
    chk({7'h0, pd}, 8'h01, "sleep without link");
    link = 1'b1;
    h.hw(2);
    chk({7'h0, pd}, 8'h00, "awake with link");
    $display("test sleep done");
    wr(pa, 8'h03, 8'h19);
    wr(pa, 8'h01, 8'h81);
    rdr(pa, 8'h01);
    chk(rd, 8'h80, "logic reset clears");
    rdr(pa, 8'h03);
    chk(rd, 8'h59, "config kept");
    chk(8'(nkeep), 8'h01, "logic reset pulse");
    wr(pa, 8'h00, {a, 1'b1});
    wr(a, 8'h01, 8'h02);
    chk({1'b0, act}, {1'b0, pa}, "address reg reset");
    rdr(pa, 8'h03);
    chk(rd, 8'hd2, "config restored");
    rdr(pa, 8'h01);
    chk(rd, 8'h00, "reset reg restored");
    chk(8'(nfull), 8'h01, "full reset pulse");
    $display("test resets done");
    wr(pa, 8'h03, 8'h13);
    fix = 1'b1;
    sy = 3'h0;
    repeat (3) @(posedge pclk);
    h.hw(6);
    chk({8'h00, vo.rgb}, {8'h00, vr.rgb}, "rising capture");
    chk({5'h0, vo.hs, vo.vs, vo.de}, 8'h00, "syncs settled");
    @(negedge pclk);
    h.hw(6);
    chk({8'h00, vo.rgb}, {8'h00, vr.rgb}, "no capture on fall");
    sy = 3'h7;
    @(posedge pclk);
    h.hw(6);
    chk({5'h0, vo.hs, vo.vs, vo.de}, 8'h00, "one strobe held back");
    sy = 3'h0;
    @(posedge pclk);
    h.hw(6);
    chk({5'h0, vo.hs, vo.vs, vo.de}, 8'h00, "short pulse rejected");
    sy = 3'h7;
    repeat (2) @(posedge pclk);
    h.hw(6);
    chk({5'h0, vo.hs, vo.vs, vo.de}, 8'h07, "long pulse passed");
    wr(pa, 8'h03, 8'h02);
    sy = 3'h5;
    @(negedge pclk);
    @(posedge pclk);
    h.hw(6);
    chk({5'h0, vo.hs, vo.vs, vo.de}, 8'h05, "filter off follows");
    chk({8'h00, vo.rgb}, {8'h00, vf.rgb}, "falling capture");
    fix = 1'b0;
    $display("test video done");
    prun = 1'b0;
    h.hw(80);
    chk({7'h0, osc}, 8'h01, "oscillator on loss");
    prun = 1'b1;
    h.hw(40);
    chk({7'h0, osc}, 8'h00, "oscillator released");
    $display("test oscillator done");
    rta = {3'h2, 4'(xs())};
    frd = 8'(xs());
    rack = 1'b0;
    probe(rta);
    chk({7'h0, ack}, 8'h00, "remote nack passed");
    rack = 1'b1;
    probe(rta);
    chk({7'h0, ack}, 8'h01, "remote ack passed");
    wr(pa, 8'h03, 8'hf2);
    rack = 1'b0;
    probe(rta);
    chk({7'h0, ack}, 8'h01, "auto acknowledge");
    probe(7'h55);
    chk({7'h0, ack}, 8'h00, "foreign address");
    wr(pa, 8'h03, 8'hfa);
    probe(7'h55);
    chk({7'h0, ack}, 8'h01, "pass through write");
    rack = 1'b1;
    h.start();
    h.wbyte({rta, 1'b1}, ack);
    h.rbyte(rd);
    h.stop();
    chk(rd, frd, "remote read");
    chk(8'(nstart), 8'h05, "forwarded starts");
    $display("test remote done");
    report_and_stop();
  end
endmodule
